// *** core/ppr_top.sv ***
/*
 * Peripheral pin remap: one configuration register behind an AXI4-Lite slave,
 * decoded into a registered pin assignment for each remappable peripheral signal.
 * Assumes the pad ring consumes the pin identifiers and that the AXI master
 * keeps valid and payload stable until ready.
 */
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ppr_top
    import ppr_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire logic [ADDR_W-1:0]     axi_awaddr_i,
    input  wire logic                  axi_awvalid_i,
    output logic                       axi_awready_o,
    input  wire logic [DATA_W-1:0]     axi_wdata_i,
    input  wire logic [DATA_W/8-1:0]   axi_wstrb_i,
    input  wire logic                  axi_wvalid_i,
    output logic                       axi_wready_o,
    output logic [1:0]                 axi_bresp_o,
    output logic                       axi_bvalid_o,
    input  wire logic                  axi_bready_i,
    input  wire logic [ADDR_W-1:0]     axi_araddr_i,
    input  wire logic                  axi_arvalid_i,
    output logic                       axi_arready_o,
    output logic [DATA_W-1:0]          axi_rdata_o,
    output logic [1:0]                 axi_rresp_o,
    output logic                       axi_rvalid_o,
    input  wire logic                  axi_rready_i,
    output ppr_tim1_route_s            tim1_route_o,
    output ppr_uart_route_s            usart1_route_o,
    output ppr_uart_route_s            usart2_route_o,
    output ppr_uart_route_s            usart3_route_o,
    output ppr_uart_route_s            usart4_route_o,
    output ppr_i2c_route_s             i2c1_route_o,
    output ppr_spi_route_s             spi1_route_o
);

    // =====================================================================
    // Routing decoders
    localparam ppr_uart_route_s UART_NONE = '{PIN_NONE, PIN_NONE, PIN_NONE, PIN_NONE, PIN_NONE};

    function automatic ppr_tim1_route_s dec_tim1(input logic [2:0] c);
        ppr_tim1_route_s r;
        r = '{default: PIN_NONE};
        // Codes 000 and 001 are routed by another block, so they claim no pin here
        if (c[2]) begin
            r.ch3                    = pc(5'h0e);
            r.external_trigger_input = pc(5'h0f);
        end else if (c[1:0] == 2'h2) begin
            r = '{pb(5'h09), pb(5'h0a), pb(5'h0b), pb(5'h0c), pc(5'h12), pb(5'h05),
                  pb(5'h06), pb(5'h07), pb(5'h08)};
        end else if (c[1:0] == 2'h3) begin
            r = '{pc(5'h00), pc(5'h01), pc(5'h02), pc(5'h03), pc(5'h12), pc(5'h04),
                  pc(5'h05), pc(5'h06), pc(5'h07)};
        end
        return r;
    endfunction : dec_tim1

    function automatic ppr_uart_route_s dec_usart4(input logic [2:0] c);
        ppr_uart_route_s r;
        r = UART_NONE;
        casez (c)
            3'b000:  r = '{pb(5'h01), pb(5'h0f), pb(5'h00), pb(5'h02), pa(5'h08)};
            3'b001:  r = '{pa(5'h09), pa(5'h07), pa(5'h05), pa(5'h06), pb(5'h15)};
            3'b010:  r = '{pc(5'h11), pb(5'h0f), pc(5'h10), pb(5'h02), pa(5'h08)};
            3'b011:  r = '{pa(5'h0a), pa(5'h0e), pb(5'h09), pb(5'h08), pa(5'h0d)};
            3'b1?0:  r = '{pc(5'h13), pa(5'h05), pb(5'h0d), pa(5'h08), pa(5'h06)};
            3'b1?1:  r = '{pc(5'h10), pb(5'h0f), pc(5'h11), pb(5'h02), pa(5'h08)};
            default: r = UART_NONE;
        endcase
        return r;
    endfunction : dec_usart4

    function automatic ppr_uart_route_s dec_usart3(input logic [1:0] c);
        ppr_uart_route_s r;
        r = UART_NONE;
        case (c)
            2'h0:    r = '{pb(5'h04), pb(5'h06), pb(5'h03), pb(5'h05), pb(5'h07)};
            2'h1:    r = '{pc(5'h13), pb(5'h06), pc(5'h12), pb(5'h05), pb(5'h07)};
            2'h2:    r = '{pb(5'h0e), pa(5'h03), pa(5'h12), pb(5'h08), pa(5'h04)};
            default: r = UART_NONE;
        endcase
        return r;
    endfunction : dec_usart3

    function automatic ppr_uart_route_s dec_usart2(input logic [2:0] c);
        ppr_uart_route_s r;
        r = UART_NONE;
        casez (c)
            3'b000:  r = '{pa(5'h03), pa(5'h00), pa(5'h02), pa(5'h04), pa(5'h01)};
            3'b001:  r = '{pa(5'h13), pa(5'h01), pa(5'h14), pa(5'h17), pa(5'h02)};
            3'b010:  r = '{pa(5'h10), pa(5'h11), pa(5'h0f), pa(5'h16), pa(5'h15)};
            3'b011:  r = '{pc(5'h01), pc(5'h02), pc(5'h00), pb(5'h14), pc(5'h03)};
            3'b1??:  r = '{pa(5'h10), pa(5'h11), pa(5'h0f), pa(5'h16), pc(5'h03)};
            default: r = UART_NONE;
        endcase
        return r;
    endfunction : dec_usart2

    function automatic ppr_uart_route_s dec_usart1(input logic [1:0] c);
        ppr_uart_route_s r;
        r = UART_NONE;
        case (c)
            2'h0:    r = '{pb(5'h0b), pc(5'h10), pb(5'h0a), pb(5'h09), pc(5'h11)};
            2'h1:    r = '{pa(5'h0b), pc(5'h10), pa(5'h0a), pb(5'h09), pc(5'h11)};
            2'h2:    r = '{pb(5'h0b), pa(5'h09), pb(5'h0a), pb(5'h05), pa(5'h08)};
            default: r = '{pb(5'h02), pa(5'h0d), pa(5'h07), pb(5'h0c), pa(5'h0e)};
        endcase
        return r;
    endfunction : dec_usart1

    function automatic ppr_i2c_route_s dec_i2c1(input logic [2:0] c);
        ppr_i2c_route_s r;
        r = '{PIN_NONE, PIN_NONE};
        casez (c)
            3'b000:  r = '{pa(5'h0a), pa(5'h0b)};
            3'b001:  r = '{pa(5'h0d), pa(5'h0e)};
            3'b010:  r = '{pc(5'h10), pc(5'h11)};
            3'b011:  r = '{pc(5'h13), pc(5'h12)};
            3'b1?0:  r = '{pc(5'h11), pc(5'h10)};
            3'b1?1:  r = '{pc(5'h12), pc(5'h13)};
            default: r = '{PIN_NONE, PIN_NONE};
        endcase
        return r;
    endfunction : dec_i2c1

    function automatic ppr_spi_route_s dec_spi1(input logic [1:0] c);
        ppr_spi_route_s r;
        r = '{PIN_NONE, PIN_NONE, PIN_NONE, PIN_NONE};
        case (c)
            2'h0:    r = '{pa(5'h04), pa(5'h05), pa(5'h06), pa(5'h07)};
            2'h1:    r = '{pb(5'h15), pb(5'h0f), pa(5'h08), pa(5'h09)};
            2'h2:    r = '{pa(5'h0c), pa(5'h0b), pa(5'h09), pa(5'h0a)};
            default: r = '{pc(5'h04), pc(5'h05), pc(5'h06), pc(5'h07)};
        endcase
        return r;
    endfunction : dec_spi1

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return a == OFS_REMAP_CFG;
    endfunction : addr_hit

    // =====================================================================
    // State
    logic                  aw_held_q, aw_held_d;
    logic                  w_held_q, w_held_d;
    logic [ADDR_W-1:0]     awaddr_q, awaddr_d;
    logic [DATA_W-1:0]     wdata_q, wdata_d;
    logic [DATA_W/8-1:0]   wstrb_q, wstrb_d;
    logic                  awready_q, awready_d;
    logic                  wready_q, wready_d;
    logic                  bvalid_q, bvalid_d;
    logic [1:0]            bresp_q, bresp_d;
    logic                  arready_q, arready_d;
    logic                  rvalid_q, rvalid_d;
    logic [1:0]            rresp_q, rresp_d;
    logic [DATA_W-1:0]     rdata_q, rdata_d;
    logic [DATA_W-1:0]     cfg_q, cfg_d;
    ppr_tim1_route_s       tim1_q, tim1_d;
    ppr_uart_route_s       u1_q, u1_d, u2_q, u2_d, u3_q, u3_d, u4_q, u4_d;
    ppr_i2c_route_s        i2c_q, i2c_d;
    ppr_spi_route_s        spi_q, spi_d;
    logic                  wr_commit;

    // =====================================================================
    // AXI4-Lite slave and configuration register
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        cfg_d     = cfg_q;
        wr_commit = aw_held_q && w_held_q && !bvalid_q;
        if (axi_awvalid_i && awready_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = axi_awaddr_i;
        end
        if (axi_wvalid_i && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = axi_wdata_i;
            wstrb_d  = axi_wstrb_i;
        end
        if (bvalid_q && axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (wr_commit) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (addr_hit(awaddr_q)) begin
                for (int b = 0; b < DATA_W/8; b++) begin
                    if (wstrb_q[b]) begin
                        cfg_d[b*8 +: 8] = wdata_q[b*8 +: 8] & CFG_RW_MASK[b*8 +: 8];
                    end
                end
            end
        end
        // Each address/data slot reopens only once its response has gone
        awready_d = !aw_held_d && !bvalid_d;
        wready_d  = !w_held_d && !bvalid_d;
        if (rvalid_q && axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        if (axi_arvalid_i && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = addr_hit(axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = addr_hit(axi_araddr_i) ? (cfg_q & CFG_RW_MASK) : '0;
        end
        arready_d = !rvalid_d;
        // Decoded from the next value so every field changes in one edge
        tim1_d = dec_tim1(cfg_d[TIM1_LSB +: 3]);
        u4_d   = dec_usart4(cfg_d[USART4_LSB +: 3]);
        u3_d   = dec_usart3(cfg_d[USART3_LSB +: 2]);
        u2_d   = dec_usart2(cfg_d[USART2_LSB +: 3]);
        u1_d   = dec_usart1(cfg_d[USART1_LSB +: 2]);
        i2c_d  = dec_i2c1(cfg_d[I2C1_LSB +: 3]);
        spi_d  = dec_spi1(cfg_d[SPI1_LSB +: 2]);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
            cfg_q     <= CFG_RESET;
            tim1_q    <= dec_tim1(CFG_RESET[TIM1_LSB +: 3]);
            u4_q      <= dec_usart4(CFG_RESET[USART4_LSB +: 3]);
            u3_q      <= dec_usart3(CFG_RESET[USART3_LSB +: 2]);
            u2_q      <= dec_usart2(CFG_RESET[USART2_LSB +: 3]);
            u1_q      <= dec_usart1(CFG_RESET[USART1_LSB +: 2]);
            i2c_q     <= dec_i2c1(CFG_RESET[I2C1_LSB +: 3]);
            spi_q     <= dec_spi1(CFG_RESET[SPI1_LSB +: 2]);
        end else if (ce_i) begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            cfg_q     <= cfg_d;
            tim1_q    <= tim1_d;
            u4_q      <= u4_d;
            u3_q      <= u3_d;
            u2_q      <= u2_d;
            u1_q      <= u1_d;
            i2c_q     <= i2c_d;
            spi_q     <= spi_d;
        end
    end

    assign axi_awready_o  = awready_q;
    assign axi_wready_o   = wready_q;
    assign axi_bvalid_o   = bvalid_q;
    assign axi_bresp_o    = bresp_q;
    assign axi_arready_o  = arready_q;
    assign axi_rvalid_o   = rvalid_q;
    assign axi_rresp_o    = rresp_q;
    assign axi_rdata_o    = rdata_q;
    assign tim1_route_o   = tim1_q;
    assign usart1_route_o = u1_q;
    assign usart2_route_o = u2_q;
    assign usart3_route_o = u3_q;
    assign usart4_route_o = u4_q;
    assign i2c1_route_o   = i2c_q;
    assign spi1_route_o   = spi_q;

    // =====================================================================
    // Checks
    tim1_pb_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[TIM1_LSB +: 3] == 3'h2 |-> tim1_q.ch4 == pb(5'h0c)
            && tim1_q.external_trigger_input == pc(5'h12) && tim1_q.break_input == pb(5'h05))
        else $error("timer1 code 010 routing wrong");

    tim1_pc_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[TIM1_LSB +: 3] == 3'h3 |-> tim1_q.ch1 == pc(5'h00)
            && tim1_q.complementary_output_3 == pc(5'h07))
        else $error("timer1 code 011 routing wrong");

    tim1_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[TIM1_LSB + 2] |-> tim1_q.ch3 == pc(5'h0e) && tim1_q.ch1 == PIN_NONE
            && tim1_q.break_input == PIN_NONE && tim1_q.external_trigger_input == pc(5'h0f))
        else $error("timer1 code 1xx routing wrong");

    usart4_mid_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[USART4_LSB +: 3] == 3'h6 |-> u4_q.rx == pc(5'h13) && u4_q.tx == pb(5'h0d))
        else $error("usart4 code 110 routing wrong");

    usart3_none_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[USART3_LSB +: 2] == 2'h3 |-> u3_q == UART_NONE)
        else $error("usart3 code 11 claims a pin");

    usart2_rts_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[USART2_LSB + 2] |-> u2_q.rts == pc(5'h03) && u2_q.rx == pa(5'h10))
        else $error("usart2 code 1xx routing wrong");

    usart1_alt_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[USART1_LSB +: 2] == 2'h1 |-> u1_q.rx == pa(5'h0b) && u1_q.cts == pc(5'h10))
        else $error("usart1 code 01 routing wrong");

    i2c_swap_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[I2C1_LSB +: 3] == 3'h5 |-> i2c_q.scl == pc(5'h12) && i2c_q.sda == pc(5'h13))
        else $error("i2c1 code 1x1 routing wrong");

    spi_last_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_q[SPI1_LSB +: 2] == 2'h3 |-> spi_q.nss == pc(5'h04) && spi_q.mosi == pc(5'h07))
        else $error("spi1 code 11 routing wrong");

    write_apply_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && wr_commit && addr_hit(awaddr_q) && wstrb_q[1] |=>
            cfg_q[USART3_LSB +: 2] == $past(wdata_q[USART3_LSB +: 2])
            && u3_q == dec_usart3($past(wdata_q[USART3_LSB +: 2])) && bvalid_q)
        else $error("written remap field not applied next cycle");

    reset_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> cfg_q == CFG_RESET && u4_q.rx == pb(5'h01) && !bvalid_q)
        else $error("remap fields not zero after reset");

    unmapped_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && axi_arvalid_i && arready_q && !addr_hit(axi_araddr_i) |=>
            rvalid_q && rresp_q == RESP_SLVERR && rdata_q == '0)
        else $error("unmapped read not answered with error");

    ce_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !ce_i |=> $stable(cfg_q) && $stable(tim1_q) && $stable(u4_q) && $stable(bvalid_q))
        else $error("state moved while clock enable low");

endmodule : ppr_top

// *** core/ppr_pkg.sv ***
/*
 * Constants, field layout and routing types for the peripheral pin remap block.
 * Assumes one 250 MHz system clock, a synchronous reset and an AXI4-Lite master.
 */
// Contract
// - Timer1 code 010: channels on PB5-PB12, PC18
// - Timer1 code 011: channels on PC0-PC7, PC18
// - Timer1 code 1xx: only CH3 PC14, trigger PC15
// - Usart4 field bits 14:12, code 000 default pins
// - Usart4 code 001 routes onto PA9/PA7/PA5/PA6/PB21
// - Usart4 code 010 routes onto PC17/PB15/PC16/PB2/PA8
// - Usart4 code 011 routes onto PA10/PA14/PB9/PB8/PA13
// - Usart4 codes 1x0 and 1x1 ignore middle bit
// - Usart3 field bits 11:10, codes 00 and 01
// - Usart3 code 10 routes onto PB14/PA3/PA18/PB8/PA4
// - Usart2 field bits 9:7, codes 000 and 001
// - Usart2 code 010 and 1xx, 1xx RTS PC3
// - Usart2 code 011 routes onto PC1/PC2/PC0/PB20/PC3
// - Usart1 field bits 6:5, codes 00 and 01
// - Usart1 codes 10 and 11 pin sets
// - I2c1 field bits 4:2, codes 000 to 011
// - I2c1 codes 1x0 and 1x1 ignore middle bit
// - Spi1 field bits 1:0, codes 00 and 01
// - Spi1 codes 10 and 11 pin sets
// - All fields read/write, reset to zero
package ppr_pkg;

    // =====================================================================
    // Bus and register map
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_REMAP_CFG = 8'h00;
    localparam logic [31:0] CFG_RW_MASK   = 32'h0003ffff;
    localparam logic [31:0] CFG_RESET     = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // =====================================================================
    // Field positions
    localparam int TIM1_LSB   = 15;
    localparam int USART4_LSB = 12;
    localparam int USART3_LSB = 10;
    localparam int USART2_LSB = 7;
    localparam int USART1_LSB = 5;
    localparam int I2C1_LSB   = 2;
    localparam int SPI1_LSB   = 0;

    // =====================================================================
    // Pin identifier: port code in [6:5], pin number in [4:0]
    typedef logic [6:0] ppr_pin_t;
    localparam logic [1:0] PORT_A   = 2'h1;
    localparam logic [1:0] PORT_B   = 2'h2;
    localparam logic [1:0] PORT_C   = 2'h3;
    localparam ppr_pin_t   PIN_NONE = 7'h00;

    function automatic ppr_pin_t pa(input logic [4:0] n);
        return {PORT_A, n};
    endfunction : pa

    function automatic ppr_pin_t pb(input logic [4:0] n);
        return {PORT_B, n};
    endfunction : pb

    function automatic ppr_pin_t pc(input logic [4:0] n);
        return {PORT_C, n};
    endfunction : pc

    typedef struct packed {
        ppr_pin_t ch1;
        ppr_pin_t ch2;
        ppr_pin_t ch3;
        ppr_pin_t ch4;
        ppr_pin_t external_trigger_input;
        ppr_pin_t break_input;
        ppr_pin_t complementary_output_1;
        ppr_pin_t complementary_output_2;
        ppr_pin_t complementary_output_3;
    } ppr_tim1_route_s;

    typedef struct packed {
        ppr_pin_t rx;
        ppr_pin_t cts;
        ppr_pin_t tx;
        ppr_pin_t ck;
        ppr_pin_t rts;
    } ppr_uart_route_s;

    typedef struct packed {
        ppr_pin_t scl;
        ppr_pin_t sda;
    } ppr_i2c_route_s;

    typedef struct packed {
        ppr_pin_t nss;
        ppr_pin_t sck;
        ppr_pin_t miso;
        ppr_pin_t mosi;
    } ppr_spi_route_s;

endpackage : ppr_pkg

// *** tb/ppr_pad_model.sv ***
/*
 * Pad-ring stand-in: watches the pin ids handed out by the remap block and
 * counts every cycle in which the routing changes.
 * Assumes the routes arrive as one flat vector on the system clock.
 */
`timescale 1ns/1ps
module ppr_pad_model
    import ppr_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [244:0] routes_i,
    output logic      [15:0]  change_cnt_o
);
    logic [244:0] last_q;
    logic [15:0]  cnt_d;

    // =====================================================================
    // Change counter
    // A half-applied update would show as two changes for one write
    always_comb begin
        cnt_d = change_cnt_o + 16'((routes_i != last_q) ? 1 : 0);
    end

    always_ff @(posedge clk_i) begin
        last_q       <= routes_i;
        change_cnt_o <= srst_i ? 16'h0000 : cnt_d;
    end
endmodule : ppr_pad_model

// *** tb/testbench.sv ***
/*
 * Self-checking bench for the pin remap block: AXI4-Lite master tasks,
 * expected routing tables and a pad-ring observer.
 * Assumes the slave answers in its own time; a cycle ceiling cuts hangs.
 */
`timescale 1ns/1ps
module testbench
    import ppr_pkg::*;
;
    logic            clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
    logic [7:0]      axi_awaddr_i = 8'h00, axi_araddr_i = 8'h00;
    logic [31:0]     axi_wdata_i = 32'h0, axi_rdata_o, cfg_m = 32'h0;
    logic [3:0]      axi_wstrb_i = 4'h0;
    logic            axi_awvalid_i = 0, axi_wvalid_i = 0, axi_bready_i = 0;
    logic            axi_arvalid_i = 0, axi_rready_i = 0;
    logic            axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
    logic [1:0]      axi_bresp_o, axi_rresp_o;
    ppr_tim1_route_s tim1_route_o;
    ppr_uart_route_s usart1_route_o, usart2_route_o, usart3_route_o, usart4_route_o;
    ppr_i2c_route_s  i2c1_route_o;
    ppr_spi_route_s  spi1_route_o;
    logic [15:0]     change_cnt;
    integer          seed = 44, mismatches = 0, check_count = 0, cyc = 0;
    wire  [244:0]    routes = {tim1_route_o, usart4_route_o, usart3_route_o, usart2_route_o,
                               usart1_route_o, i2c1_route_o, spi1_route_o};

    ppr_top i_dut (.clk_i, .srst_i, .ce_i, .axi_awaddr_i, .axi_awvalid_i, .axi_awready_o,
        .axi_wdata_i, .axi_wstrb_i, .axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o,
        .axi_bready_i, .axi_araddr_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o,
        .axi_rresp_o, .axi_rvalid_o, .axi_rready_i, .tim1_route_o, .usart1_route_o,
        .usart2_route_o, .usart3_route_o, .usart4_route_o, .i2c1_route_o, .spi1_route_o);
    ppr_pad_model i_pads (.clk_i, .srst_i, .routes_i(routes), .change_cnt_o(change_cnt));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // =====================================================================
    // Expected routing
    function automatic ppr_pin_t qa(int n); return {PORT_A, n[4:0]}; endfunction : qa
    function automatic ppr_pin_t qb(int n); return {PORT_B, n[4:0]}; endfunction : qb
    function automatic ppr_pin_t qc(int n); return {PORT_C, n[4:0]}; endfunction : qc

    function automatic ppr_uart_route_s e_uart(logic [4:0] k);
        casez (k)
            5'b00000: return {qb(1), qb(15), qb(0), qb(2), qa(8)};
            5'b00001: return {qa(9), qa(7), qa(5), qa(6), qb(21)};
            5'b00010: return {qc(17), qb(15), qc(16), qb(2), qa(8)};
            5'b00011: return {qa(10), qa(14), qb(9), qb(8), qa(13)};
            5'b001?0: return {qc(19), qa(5), qb(13), qa(8), qa(6)};
            5'b001?1: return {qc(16), qb(15), qc(17), qb(2), qa(8)};
            5'b01000: return {qb(4), qb(6), qb(3), qb(5), qb(7)};
            5'b01001: return {qc(19), qb(6), qc(18), qb(5), qb(7)};
            5'b01010: return {qb(14), qa(3), qa(18), qb(8), qa(4)};
            5'b10000: return {qa(3), qa(0), qa(2), qa(4), qa(1)};
            5'b10001: return {qa(19), qa(1), qa(20), qa(23), qa(2)};
            5'b10010: return {qa(16), qa(17), qa(15), qa(22), qa(21)};
            5'b10011: return {qc(1), qc(2), qc(0), qb(20), qc(3)};
            5'b101??: return {qa(16), qa(17), qa(15), qa(22), qc(3)};
            5'b11000: return {qb(11), qc(16), qb(10), qb(9), qc(17)};
            5'b11001: return {qa(11), qc(16), qa(10), qb(9), qc(17)};
            5'b11010: return {qb(11), qa(9), qb(10), qb(5), qa(8)};
            5'b11011: return {qb(2), qa(13), qa(7), qb(12), qa(14)};
            default:  return '0;
        endcase
    endfunction : e_uart

    function automatic logic [244:0] exp_all(logic [31:0] c);
        logic [62:0] t;
        logic [13:0] i;
        logic [27:0] s;
        casez (c[17:15])
            3'b010:  t = {qb(9), qb(10), qb(11), qb(12), qc(18), qb(5), qb(6), qb(7), qb(8)};
            3'b011:  t = {qc(0), qc(1), qc(2), qc(3), qc(18), qc(4), qc(5), qc(6), qc(7)};
            3'b1??:  t = {14'h0, qc(14), 7'h00, qc(15), 28'h0};
            default: t = '0;
        endcase
        casez (c[4:2])
            3'b000:  i = {qa(10), qa(11)};
            3'b001:  i = {qa(13), qa(14)};
            3'b010:  i = {qc(16), qc(17)};
            3'b011:  i = {qc(19), qc(18)};
            3'b1?0:  i = {qc(17), qc(16)};
            default: i = {qc(18), qc(19)};
        endcase
        case (c[1:0])
            2'h0:    s = {qa(4), qa(5), qa(6), qa(7)};
            2'h1:    s = {qb(21), qb(15), qa(8), qa(9)};
            2'h2:    s = {qa(12), qa(11), qa(9), qa(10)};
            default: s = {qc(4), qc(5), qc(6), qc(7)};
        endcase
        return {t, e_uart({2'h0, c[14:12]}), e_uart({3'h2, c[11:10]}),
                e_uart({2'h2, c[9:7]}), e_uart({3'h6, c[6:5]}), i, s};
    endfunction : exp_all

    // =====================================================================
    // Checking and bus tasks
    task automatic chk(logic [244:0] seen, logic [244:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
        axi_awaddr_i  <= a;
        axi_wdata_i   <= d;
        axi_wstrb_i   <= s;
        axi_awvalid_i <= 1'b1;
        axi_wvalid_i  <= 1'b1;
        axi_bready_i  <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (ce_i && axi_awvalid_i && axi_awready_o === 1'b1) axi_awvalid_i <= 1'b0;
            if (ce_i && axi_wvalid_i && axi_wready_o === 1'b1) axi_wvalid_i <= 1'b0;
            if (ce_i && axi_bvalid_o === 1'b1) break;
        end
        chk(axi_bresp_o, er);
        axi_bready_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        axi_araddr_i  <= a;
        axi_arvalid_i <= 1'b1;
        axi_rready_i  <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (ce_i && axi_arvalid_i && axi_arready_o === 1'b1) axi_arvalid_i <= 1'b0;
            if (ce_i && axi_rvalid_o === 1'b1) break;
        end
        chk(axi_rdata_o, ed);
        chk(axi_rresp_o, er);
        axi_rready_i <= 1'b0;
        @(posedge clk_i);
    endtask : rd

    // Write, then compare routing, pad change count and read-back
    task automatic step(logic [7:0] a, logic [31:0] d, logic [3:0] s);
        logic [31:0] nxt;
        logic [15:0] n0;
        logic [1:0]  er;
        er  = (a == OFS_REMAP_CFG) ? RESP_OKAY : RESP_SLVERR;
        nxt = cfg_m;
        for (int b = 0; b < 4; b++) begin
            if (s[b] && a == OFS_REMAP_CFG) nxt[8*b+:8] = d[8*b+:8];
        end
        nxt = nxt & CFG_RW_MASK;
        n0  = change_cnt;
        wr(a, d, s, er);
        chk(change_cnt - n0, exp_all(nxt) != exp_all(cfg_m));
        cfg_m = nxt;
        chk(routes, exp_all(cfg_m));
        rd(a, (a == OFS_REMAP_CFG) ? cfg_m : 32'h0, er);
    endtask : step

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        ce_i <= (cyc % 7) < 5;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            conclude();
        end
    end

    // Outputs hold across any edge at which ce_i is low and srst_i is not
    logic         hold_q = 1'b0;
    logic [244:0] rsnap_q;
    logic [40:0]  bsnap_q;
    wire  [40:0]  bus = {axi_awready_o, axi_wready_o, axi_bvalid_o, axi_bresp_o, axi_arready_o,
                         axi_rvalid_o, axi_rresp_o, axi_rdata_o};
    always @(negedge clk_i) begin
        if (hold_q) begin
            chk(routes, rsnap_q);
            chk(bus, bsnap_q);
        end
        hold_q  <= !ce_i && !srst_i;
        rsnap_q <= routes;
        bsnap_q <= bus;
    end

    // =====================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk(routes, exp_all(32'h0));
        rd(OFS_REMAP_CFG, 32'h0, RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            r = k;
            step(OFS_REMAP_CFG, {14'h0, r[2:0], r[2:0], r[1:0], r[2:0], r[1:0], r[2:0],
                                 r[1:0]}, 4'hf);
        end
        step(8'h04, 32'hffffffff, 4'hf);
        step(OFS_REMAP_CFG, 32'hffffffff, 4'h2);
        repeat (150) begin
            r = $random(seed);
            step((r[31:28] == 4'h0) ? 8'h04 : OFS_REMAP_CFG, $random(seed), r[3:0]);
        end
        conclude();
    end
endmodule : testbench
